// *** hw/itd_regs.svh ***
// Field positions, opcode encodings and timing counts of the instruction decoder
`ifndef ITD_REGS_SVH
`define ITD_REGS_SVH

// ****************************************************************
// Instruction word layout
// ****************************************************************
`define ITD_IW_W 14
`define ITD_CLS_MSB 13
`define ITD_CLS_LSB 12
`define ITD_SUB_MSB 11
`define ITD_SUB_LSB 8
`define ITD_BITOP_MSB 11
`define ITD_BITOP_LSB 10
`define ITD_B_MSB 9
`define ITD_B_LSB 7
`define ITD_D_POS 7
`define ITD_F_MSB 6
`define ITD_F_LSB 0
`define ITD_N_POS 6
`define ITD_CALL_POS 11
`define ITD_REL_MSB 11
`define ITD_REL_LSB 9
`define ITD_MISC_MSB 3
`define ITD_MISC_LSB 0

// ****************************************************************
// Opcode encodings
// ****************************************************************
`define ITD_CLS_BYTE 2'h0
`define ITD_CLS_BIT 2'h1
`define ITD_CLS_CTRL 2'h2
`define ITD_CLS_LIT 2'h3
`define ITD_BY_MOVWF 4'h0
`define ITD_BY_MOVF 4'h1
`define ITD_BY_DECSKZ 4'h2
`define ITD_BY_INCSKZ 4'h3
`define ITD_BY_ADD 4'h4
`define ITD_BY_AND 4'h5
`define ITD_BY_OR 4'h6
`define ITD_BY_XOR 4'h7
`define ITD_BIT_CLR 2'h0
`define ITD_BIT_SET 2'h1
`define ITD_BIT_SKC 2'h2
`define ITD_BIT_SKS 2'h3
`define ITD_LIT_MISC 4'h0
`define ITD_LIT_PTR 4'h1
`define ITD_LIT_REL 3'h1
`define ITD_LIT_RETURN_WITH_LITERAL_OP 4'h4
`define ITD_LIT_MOVLW 4'h8
`define ITD_MISC_NOP 4'h0
`define ITD_MISC_RET 4'h1
`define ITD_MISC_RETINT 4'h2
`define ITD_MISC_BRW 4'h3
`define ITD_MISC_CALL_VIA_WREG_OP 4'h4
`define ITD_INDF0_ADDR 7'h00
`define ITD_INDF1_ADDR 7'h01

// ****************************************************************
// Timing
// ****************************************************************
`define ITD_CLK_PERIOD_NS 10
`define ITD_ICYC_NS 40
`define ITD_PHASES (`ITD_ICYC_NS / `ITD_CLK_PERIOD_NS)
`define ITD_PH_FETCH 2'h0
`define ITD_PH_READ 2'h1
`define ITD_PH_MODIFY 2'h2
`define ITD_PH_WRITE 2'h3

`endif

// *** hw/itd_pkg.sv ***
// Types shared by the instruction decoder modules
package itd_pkg;

   // Sequencer states of one instruction cycle
   typedef enum logic [1:0] {
      st_exec  = 2'h0,
      st_extra = 2'h1,
      st_flush = 2'h2
   } itd_state_t;

   // Decoded operations
   typedef enum logic [4:0] {
      nop_op                 = 5'h00,
      move_w_to_f_op         = 5'h01,
      move_f_op              = 5'h02,
      decrement_skip_zero_op = 5'h03,
      increment_skip_zero_op = 5'h04,
      add_op                 = 5'h05,
      and_op                 = 5'h06,
      or_op                  = 5'h07,
      xor_op                 = 5'h08,
      bit_clear_op           = 5'h09,
      bit_set_op             = 5'h0a,
      skip_if_bit_clear_op   = 5'h0b,
      skip_if_bit_set_op     = 5'h0c,
      absolute_jump_op       = 5'h0d,
      call_op                = 5'h0e,
      call_via_wreg_op       = 5'h0f,
      return_op              = 5'h10,
      return_with_literal_op = 5'h11,
      interrupt_return_op    = 5'h12,
      relative_branch_op     = 5'h13,
      branch_by_wreg_op      = 5'h14,
      move_literal_op        = 5'h15,
      pointer_adjust_op      = 5'h16
   } itd_op_t;

endpackage

// *** hw/itd_phase_gen.sv ***
// Divider that splits the oscillator into the four phases of an instruction cycle
`include "itd_regs.svh"

module itd_phase_gen
   import itd_pkg::*;
#(
   parameter int PHASES = `ITD_PHASES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Phase of the instruction cycle
   output logic [1:0] phase_q,
   output logic cycle_end
);

   // Free running phase count, wraps after the last oscillator period
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= 2'h0;
      end else if (phase_q == 2'(PHASES - 1)) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // Last period of the instruction cycle
   assign cycle_end = (phase_q == 2'(PHASES - 1));

endmodule

// *** hw/itd_field_decode.sv ***
// Splits a 14-bit instruction word into its operation and operand fields
`include "itd_regs.svh"

module itd_field_decode
   import itd_pkg::*;
(
   // Instruction word
   input wire logic [`ITD_IW_W-1:0] ir,
   // Decoded operation and operands
   output itd_op_t op,
   output logic dest_f,
   output logic [6:0] faddr,
   output logic [2:0] bit_sel,
   output logic ptr_num,
   output logic [10:0] lit
);

   logic [1:0] cls;
   logic [3:0] sub;

   // Operand fields sit at fixed places in the word
   assign cls = ir[`ITD_CLS_MSB:`ITD_CLS_LSB];
   assign sub = ir[`ITD_SUB_MSB:`ITD_SUB_LSB];
   assign faddr = ir[`ITD_F_MSB:`ITD_F_LSB];
   assign dest_f = ir[`ITD_D_POS];
   assign bit_sel = ir[`ITD_B_MSB:`ITD_B_LSB];
   assign ptr_num = ir[`ITD_N_POS];
   assign lit = ir[10:0];

   // Opcode decode; misc words look only at their low nibble so don't-care bits are ignored
   always_comb begin
      op = nop_op;
      unique case (cls)
         `ITD_CLS_BYTE: begin
            unique case (sub)
               `ITD_BY_MOVWF: op = move_w_to_f_op;
               `ITD_BY_MOVF: op = move_f_op;
               `ITD_BY_DECSKZ: op = decrement_skip_zero_op;
               `ITD_BY_INCSKZ: op = increment_skip_zero_op;
               `ITD_BY_ADD: op = add_op;
               `ITD_BY_AND: op = and_op;
               `ITD_BY_OR: op = or_op;
               `ITD_BY_XOR: op = xor_op;
               default: op = nop_op;
            endcase
         end
         `ITD_CLS_BIT: begin
            unique case (ir[`ITD_BITOP_MSB:`ITD_BITOP_LSB])
               `ITD_BIT_CLR: op = bit_clear_op;
               `ITD_BIT_SET: op = bit_set_op;
               `ITD_BIT_SKC: op = skip_if_bit_clear_op;
               `ITD_BIT_SKS: op = skip_if_bit_set_op;
            endcase
         end
         `ITD_CLS_CTRL: begin
            op = ir[`ITD_CALL_POS] ? absolute_jump_op : call_op;
         end
         `ITD_CLS_LIT: begin
            if (ir[`ITD_REL_MSB:`ITD_REL_LSB] == `ITD_LIT_REL) begin
               op = relative_branch_op;
            end else if (sub == `ITD_LIT_PTR) begin
               op = pointer_adjust_op;
            end else if (sub == `ITD_LIT_RETURN_WITH_LITERAL_OP) begin
               op = return_with_literal_op;
            end else if (sub == `ITD_LIT_MOVLW) begin
               op = move_literal_op;
            end else if (sub == `ITD_LIT_MISC) begin
               unique case (ir[`ITD_MISC_MSB:`ITD_MISC_LSB])
                  `ITD_MISC_RET: op = return_op;
                  `ITD_MISC_RETINT: op = interrupt_return_op;
                  `ITD_MISC_BRW: op = branch_by_wreg_op;
                  `ITD_MISC_CALL_VIA_WREG_OP: op = call_via_wreg_op;
                  default: op = nop_op;
               endcase
            end else begin
               op = nop_op;
            end
         end
      endcase
   end

endmodule

// *** hw/itd_core_seq.sv ***
// Instruction decode and execution timing sequencer of the 8-bit core
`include "itd_regs.svh"

module itd_core_seq
   import itd_pkg::*;
#(
   parameter int PC_W = 15,
   parameter int PHASES = `ITD_PHASES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Program fetch
   input wire logic [`ITD_IW_W-1:0] instr_word,
   output logic [PC_W-1:0] fetch_addr,
   // File register port
   output logic file_rd_en,
   output logic [6:0] file_addr,
   input wire logic [7:0] file_rd_data,
   output logic file_wr_en,
   output logic [7:0] file_wr_data,
   // Working register
   input wire logic [7:0] wreg,
   output logic wreg_wr_en,
   output logic [7:0] wreg_wr_data,
   // Zero flag
   output logic zero_wr_en,
   output logic zero_wr_val,
   // File select pointers
   input wire logic [1:0] ptr_in_prog,
   output logic ptr_sel,
   output logic ptr_adj_en,
   output logic [5:0] ptr_adj_val,
   // Return stack
   output logic stack_push,
   output logic [PC_W-1:0] stack_push_addr,
   output logic stack_pop,
   input wire logic [PC_W-1:0] stack_top,
   // Interrupt enable restore
   output logic irq_reenable,
   // Progress
   output logic [1:0] phase,
   output logic instr_retire,
   output logic [1:0] retire_cycles
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [1:0] phase_q;
   logic cycle_end;
   logic [`ITD_IW_W-1:0] ir_q;
   itd_state_t state_q;
   logic flush_owned_q;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic [7:0] result_q;
   logic skip_q;
   logic [1:0] cyc_cnt_q;
   logic [1:0] retire_cycles_q;

   itd_op_t op;
   logic dest_f;
   logic [6:0] faddr;
   logic [2:0] bit_sel;
   logic ptr_num;
   logic [10:0] lit;

   logic ph_fetch, ph_read, ph_modify, ph_write;
   logic exec_valid, uses_file, is_indirect, need_ext, completing;
   logic two_cycle;
   logic writes_file;
   logic writes_wreg;
   logic sets_zero;
   logic is_skip_op;
   logic is_return;
   logic is_call;
   logic last_cycle;
   logic [7:0] bit_mask;

   // ****************************************************************
   // Phase divider and field decode
   // ****************************************************************

   // Four oscillator periods per instruction cycle
   itd_phase_gen #(
      .PHASES(PHASES)
   ) u_phase (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .phase_q(phase_q),
      .cycle_end(cycle_end)
   );

   // Fields come from the held word, so they stay stable for the whole cycle
   itd_field_decode u_decode (
      .ir(ir_q),
      .op(op),
      .dest_f(dest_f),
      .faddr(faddr),
      .bit_sel(bit_sel),
      .ptr_num(ptr_num),
      .lit(lit)
   );

   // Phase strobes
   assign ph_fetch = (phase_q == `ITD_PH_FETCH);
   assign ph_read = (phase_q == `ITD_PH_READ);
   assign ph_modify = (phase_q == `ITD_PH_MODIFY);
   assign ph_write = cycle_end && (phase_q == `ITD_PH_WRITE);

   // ****************************************************************
   // Operation classes
   // ****************************************************************

   // A flushed cycle executes as a no-operation
   assign exec_valid = (state_q != st_flush);

   // Every byte and bit operation names a file register
   assign uses_file = (op inside {move_w_to_f_op, move_f_op, decrement_skip_zero_op,
                                  increment_skip_zero_op, add_op, and_op, or_op, xor_op,
                                  bit_clear_op, bit_set_op, skip_if_bit_clear_op,
                                  skip_if_bit_set_op});

   // Indirect data registers sit at the bottom of every bank
   assign is_indirect = uses_file &&
                        (faddr == `ITD_INDF0_ADDR || faddr == `ITD_INDF1_ADDR);

   // Pointer adjust names its pointer, an indirect access uses its address bit
   assign ptr_sel = (op == pointer_adjust_op) ? ptr_num : faddr[0];

   // Extra cycle only once, while the word is first executed
   assign need_ext = exec_valid && (state_q == st_exec) && is_indirect &&
                     ptr_in_prog[ptr_sel];

   // Cycle in which the instruction writes its results
   assign completing = exec_valid && !need_ext;

   assign is_call = (op == call_op) || (op == call_via_wreg_op);
   assign is_return = (op inside {return_op, return_with_literal_op, interrupt_return_op});
   assign is_skip_op = (op inside {decrement_skip_zero_op, increment_skip_zero_op,
                                   skip_if_bit_clear_op, skip_if_bit_set_op});

   // Instructions that leave a fetched word to be discarded
   always_comb begin
      two_cycle = 1'b0;
      if (is_call) begin
         two_cycle = 1'b1;
      end else if (is_return) begin
         two_cycle = 1'b1;
      end else if (op inside {absolute_jump_op, relative_branch_op, branch_by_wreg_op}) begin
         two_cycle = 1'b1;
      end else if (is_skip_op && skip_q) begin
         two_cycle = 1'b1;
      end
   end

   // Result routing; moving W into a register writes the register always
   assign writes_file = (op == move_w_to_f_op) || (op == bit_clear_op) ||
                        (op == bit_set_op) ||
                        (dest_f && (op inside {move_f_op, decrement_skip_zero_op,
                                    increment_skip_zero_op, add_op, and_op, or_op,
                                    xor_op}));
   assign writes_wreg = (op inside {return_with_literal_op, move_literal_op}) ||
                        (!dest_f && (op inside {move_f_op, decrement_skip_zero_op,
                                     increment_skip_zero_op, add_op, and_op, or_op,
                                     xor_op}));

   // Bit operations and skips leave the flags alone
   assign sets_zero = (op inside {move_f_op, add_op, and_op, or_op, xor_op});

   // One of eight bit positions
   assign bit_mask = 8'h01 << bit_sel;

   // ****************************************************************
   // Instruction latch
   // ****************************************************************

   // A new word is taken only when a fresh instruction starts
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir_q <= 14'h0000;
      end else if (ph_fetch && state_q == st_exec) begin
         ir_q <= instr_word;
      end
   end

   // ****************************************************************
   // Read and modify phases
   // ****************************************************************

   // Register read happens even when the instruction only writes it
   assign file_rd_en = ph_read && exec_valid && uses_file;
   assign file_addr = faddr;

   // Modify phase computes the result and the skip decision
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= 8'h00;
         skip_q <= 1'b0;
      end else if (ph_modify && exec_valid) begin
         skip_q <= 1'b0;
         unique case (op)
            move_w_to_f_op: result_q <= wreg;
            move_f_op: result_q <= file_rd_data;
            decrement_skip_zero_op: begin
               result_q <= file_rd_data - 8'h01;
               skip_q <= (file_rd_data == 8'h01);
            end
            increment_skip_zero_op: begin
               result_q <= file_rd_data + 8'h01;
               skip_q <= (file_rd_data == 8'hff);
            end
            add_op: result_q <= file_rd_data + wreg;
            and_op: result_q <= file_rd_data & wreg;
            or_op: result_q <= file_rd_data | wreg;
            xor_op: result_q <= file_rd_data ^ wreg;
            bit_clear_op: result_q <= file_rd_data & ~bit_mask;
            bit_set_op: result_q <= file_rd_data | bit_mask;
            skip_if_bit_clear_op: begin
               result_q <= file_rd_data;
               skip_q <= !file_rd_data[bit_sel];
            end
            skip_if_bit_set_op: begin
               result_q <= file_rd_data;
               skip_q <= file_rd_data[bit_sel];
            end
            return_with_literal_op, move_literal_op: result_q <= lit[7:0];
            default: result_q <= result_q;
         endcase
      end
   end

   // ****************************************************************
   // Write phase strobes
   // ****************************************************************

   // Results land only in the completing cycle of a live instruction
   assign file_wr_en = ph_write && completing && writes_file;
   assign file_wr_data = result_q;
   assign wreg_wr_en = ph_write && completing && writes_wreg;
   assign wreg_wr_data = result_q;
   assign zero_wr_en = ph_write && completing && sets_zero;
   assign zero_wr_val = (result_q == 8'h00);

   // Pointer adjust and control flow strobes
   assign ptr_adj_en = ph_write && completing && (op == pointer_adjust_op);
   assign ptr_adj_val = lit[5:0];
   assign stack_push = ph_write && completing && is_call;
   assign stack_push_addr = pc_q;
   assign stack_pop = ph_write && completing && is_return;
   assign irq_reenable = ph_write && completing && (op == interrupt_return_op);

   // ****************************************************************
   // Program counter
   // ****************************************************************

   // The counter already points past the executing word, so branches add to it
   always_comb begin
      pc_d = pc_q + PC_W'(1);
      if (need_ext) begin
         pc_d = pc_q;
      end else if (completing) begin
         unique case (op)
            relative_branch_op: pc_d = pc_q + {{(PC_W - 9){lit[8]}}, lit[8:0]};
            branch_by_wreg_op: pc_d = pc_q + {{(PC_W - 8){1'b0}}, wreg};
            absolute_jump_op, call_op: pc_d = {pc_q[PC_W-1:11], lit};
            call_via_wreg_op: pc_d = {pc_q[PC_W-1:8], wreg};
            return_op, return_with_literal_op, interrupt_return_op: pc_d = stack_top;
            default: pc_d = pc_q + PC_W'(1);
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= '0;
      end else if (ph_write) begin
         pc_q <= pc_d;
      end
   end

   assign fetch_addr = pc_q;

   // ****************************************************************
   // Cycle sequencer
   // ****************************************************************

   // Reset starts in a flush so the first word is fetched before it runs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= st_flush;
         flush_owned_q <= 1'b0;
      end else if (ph_write) begin
         unique case (state_q)
            st_exec: begin
               if (need_ext) begin
                  state_q <= st_extra;
               end else if (two_cycle) begin
                  state_q <= st_flush;
                  flush_owned_q <= 1'b1;
               end
            end
            st_extra: begin
               if (two_cycle) begin
                  state_q <= st_flush;
                  flush_owned_q <= 1'b1;
               end else begin
                  state_q <= st_exec;
               end
            end
            st_flush: begin
               state_q <= st_exec;
               flush_owned_q <= 1'b0;
            end
            default: begin
               state_q <= st_flush;
               flush_owned_q <= 1'b0;
            end
         endcase
      end
   end

   // Final cycle of an instruction, including its flush cycle
   assign last_cycle = (completing && !two_cycle) ||
                       (state_q == st_flush && flush_owned_q);
   assign instr_retire = ph_write && last_cycle;

   // Cycle count of each instruction, reported when it retires
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_cnt_q <= 2'h0;
         retire_cycles_q <= 2'h0;
      end else if (ph_write && (exec_valid || flush_owned_q)) begin
         if (last_cycle) begin
            cyc_cnt_q <= 2'h0;
            retire_cycles_q <= cyc_cnt_q + 2'h1;
         end else begin
            cyc_cnt_q <= cyc_cnt_q + 2'h1;
         end
      end
   end

   assign retire_cycles = retire_cycles_q;
   assign phase = phase_q;

endmodule

// *** verification/itd_core_seq_checker.sv ***
// Port-level timing checks of the instruction sequencer
module itd_core_seq_chk (
   // Clock, reset and progress
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [1:0] phase,
   input wire logic instr_retire,
   input wire logic [1:0] retire_cycles,
   // Strobes
   input wire logic file_rd_en,
   input wire logic [6:0] file_addr,
   input wire logic file_wr_en,
   input wire logic wreg_wr_en,
   input wire logic ptr_sel,
   input wire logic stack_push,
   input wire logic stack_pop
);
   timeunit 1ns;
   timeprecision 1ps;
   // ******
   // Checks
   // ******
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // A two-cycle op retires in its flush cycle, never in the first one
   sequence flush_tail_s;
      !instr_retire ##4 instr_retire ##1 retire_cycles == 2'h2;
   endsequence
   rd_phase_a: assert property (file_rd_en |-> phase == 2'h1)
      else $error("read off phase 1");
   wr_phase_a: assert property (file_wr_en || instr_retire |-> phase == 2'h3)
      else $error("write off phase 3");
   rmw_order_a: assert property (file_wr_en |-> $past(file_rd_en, 2))
      else $error("write without read");
   retire_gap_a: assert property (instr_retire |=> !instr_retire [*3])
      else $error("retire gap short");
   call_two_a: assert property (stack_push |-> flush_tail_s)
      else $error("call length wrong");
   ret_two_a: assert property (stack_pop |-> flush_tail_s)
      else $error("return length wrong");
   one_dest_a: assert property (!(file_wr_en && wreg_wr_en))
      else $error("two destinations");
   ptr_pick_a: assert property (file_rd_en && file_addr < 7'h02 |-> ptr_sel == file_addr[0])
      else $error("wrong pointer");
endmodule

// *** verification/itd_core_seq_tb_top.sv ***
// Self-checking bench of the instruction timing sequencer
`include "itd_regs.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fails++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module itd_core_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   int fails = 0;
   int total_checks = 0;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [13:0] instr_word = 14'h3000;
   logic [7:0] file_rd_data = 8'h00;
   logic [7:0] wreg = 8'h00;
   logic [7:0] wreg_init = 8'h00;
   logic [1:0] ptr_in_prog = 2'h0;
   logic [14:0] stack_top = 15'h0200;
   logic [14:0] fetch_addr, pc, stack_push_addr, ret_addr;
   logic [6:0] file_addr;
   logic [7:0] file_wr_data, wreg_wr_data;
   logic [1:0] phase, retire_cycles, rc;
   logic file_rd_en, file_wr_en, wreg_wr_en, zero_wr_en, ptr_sel;
   logic stack_push, stack_pop, irq_reenable, instr_retire;
   logic zero_wr_val, zflag, ptr_adj_en;
   logic [5:0] ptr_adj_val;
   logic [6:0] adj;
   logic [13:0] prog [64];
   logic [7:0] fmem [128];
   logic [5:0] seen;
   itd_core_seq i_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word), .fetch_addr(fetch_addr),
      .file_rd_en(file_rd_en), .file_addr(file_addr), .file_rd_data(file_rd_data),
      .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .wreg(wreg),
      .wreg_wr_en(wreg_wr_en), .wreg_wr_data(wreg_wr_data), .zero_wr_en(zero_wr_en),
      .zero_wr_val(zero_wr_val), .ptr_in_prog(ptr_in_prog), .ptr_sel(ptr_sel),
      .ptr_adj_en(ptr_adj_en), .ptr_adj_val(ptr_adj_val), .stack_push(stack_push),
      .stack_push_addr(stack_push_addr), .stack_pop(stack_pop),
      .stack_top(stack_top), .irq_reenable(irq_reenable), .phase(phase),
      .instr_retire(instr_retire), .retire_cycles(retire_cycles));
   // ******
   // Models
   // ******
   // Memories answer one clock late, as a registered array would
   always @(posedge sys_clk) begin
      instr_word <= prog[fetch_addr[5:0]];
      file_rd_data <= fmem[file_addr];
      if (file_wr_en === 1'b1) fmem[file_addr] <= file_wr_data;
      if (!rst_n) wreg <= wreg_init;
      else if (wreg_wr_en === 1'b1) wreg <= wreg_wr_data;
      // Side values are caught at their strobe, as the registers beyond would
      if (zero_wr_en === 1'b1) zflag <= zero_wr_val;
      if (stack_push === 1'b1) ret_addr <= stack_push_addr;
      if (ptr_adj_en === 1'b1) adj <= {ptr_sel, ptr_adj_val};
   end
   // Strobes seen since the last reset
   always @(negedge sys_clk) begin
      seen <= !rst_n ? 6'h00 :
         seen | {irq_reenable, stack_pop, stack_push, zero_wr_en, wreg_wr_en, file_wr_en};
   end
   // Reset so each op starts from a known pc, then wait for it to retire
   task automatic run(input logic [13:0] w, input logic [7:0] wv, input logic [1:0] pp);
      int n;
      prog[0] = w;
      wreg_init = wv;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      ptr_in_prog <= pp;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      n = 0;
      do @(negedge sys_clk); while (instr_retire !== 1'b1 && n++ < 40);
      // A retire that never comes counts against the run
      if (instr_retire !== 1'b1) fails++;
      @(negedge sys_clk);
      rc = retire_cycles;
      pc = fetch_addr;
   endtask
   // *********
   // Scenarios
   // *********
   task automatic t_byte();
      fmem[32] = 8'h0F;
      run({`ITD_CLS_BYTE, `ITD_BY_ADD, 1'b1, 7'h20}, 8'hF1, 2'h0);
      `CHK("add to file", 8'h00, fmem[32])
      `CHK("add strobes", 6'h05, seen)
      `CHK("add cycles", 2'h1, rc)
      `CHK("add zero", 1'b1, zflag)
      fmem[127] = 8'h03;
      run({`ITD_CLS_BYTE, `ITD_BY_ADD, 1'b0, 7'h7F}, 8'h04, 2'h0);
      `CHK("add to wreg", 8'h07, wreg)
      `CHK("file kept", 8'h03, fmem[127])
      fmem[5] = 8'h01;
      run({`ITD_CLS_BYTE, `ITD_BY_DECSKZ, 1'b1, 7'h05}, 8'h00, 2'h0);
      `CHK("dec skip cycles", 2'h2, rc)
      `CHK("dec to file", 8'h00, fmem[5])
   endtask
   task automatic t_bits();
      fmem[51] = 8'hFF;
      run({`ITD_CLS_BIT, `ITD_BIT_CLR, 3'h7, 7'h33}, 8'h00, 2'h0);
      `CHK("bit clear", 8'h7F, fmem[51])
      `CHK("clear flags", 1'b0, seen[2])
      for (int i = 0; i < 4; i++) begin
         fmem[16] = i[0] ? 8'h04 : 8'hFB;
         run({`ITD_CLS_BIT, i[1] ? `ITD_BIT_SKS : `ITD_BIT_SKC, 3'h2, 7'h10}, 8'h00, 2'h0);
         `CHK("skip cycles", (i[0] == i[1]) ? 2'h2 : 2'h1, rc)
         `CHK("skip flags", 1'b0, seen[2])
      end
   endtask
   task automatic t_branch();
      run({`ITD_CLS_LIT, `ITD_LIT_REL, 9'h1FF}, 8'h00, 2'h0);
      `CHK("back branch", 15'h0001, pc)
      `CHK("branch cycles", 2'h2, rc)
      run({`ITD_CLS_LIT, `ITD_LIT_REL, 9'h0FF}, 8'h00, 2'h0);
      `CHK("fwd branch", 15'h0101, pc)
      run({`ITD_CLS_LIT, `ITD_LIT_MISC, 4'hA, `ITD_MISC_BRW}, 8'hFF, 2'h0);
      `CHK("wreg branch", 15'h0101, pc)
      run({`ITD_CLS_CTRL, 1'b1, 11'h123}, 8'h00, 2'h0);
      `CHK("jump", 15'h0124, pc)
   endtask
   task automatic t_calls();
      run({`ITD_CLS_CTRL, 1'b0, 11'h045}, 8'h00, 2'h0);
      `CHK("call target", 15'h0046, pc)
      `CHK("call push", 6'h08, seen)
      `CHK("return address", 15'h0001, ret_addr)
      run({`ITD_CLS_LIT, `ITD_LIT_MISC, 4'h0, `ITD_MISC_CALL_VIA_WREG_OP}, 8'h12, 2'h0);
      `CHK("wreg call", 15'h0013, pc)
      run({`ITD_CLS_LIT, `ITD_LIT_RETURN_WITH_LITERAL_OP, 8'h5A}, 8'h00, 2'h0);
      `CHK("literal return", 8'h5A, wreg)
      `CHK("return pc", 15'h0201, pc)
      run({`ITD_CLS_LIT, `ITD_LIT_MISC, 4'h0, `ITD_MISC_RETINT}, 8'h00, 2'h0);
      `CHK("irq return", 6'h30, seen)
   endtask
   // Only the pointer that the op names may add the extra cycle
   task automatic t_indirect();
      for (int i = 0; i < 2; i++) begin
         run({`ITD_CLS_BYTE, `ITD_BY_MOVF, 1'b1, 7'h01}, 8'h00, i[0] ? 2'h2 : 2'h1);
         `CHK("indirect cycles", i[0] ? 2'h2 : 2'h1, rc)
      end
      run({`ITD_CLS_LIT, `ITD_LIT_PTR, 2'h1, 6'h15}, 8'h00, 2'h0);
      `CHK("pointer adjust", 7'h55, adj)
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // Whole run needs well under 10 us
   initial begin
      #50000;
      fails++;
      print_verdict();
   end
   initial begin
      foreach (prog[i]) prog[i] = 14'h3000;
      t_byte();
      t_bits();
      t_branch();
      t_calls();
      t_indirect();
      print_verdict();
   end
endmodule
bind itd_core_seq itd_core_seq_chk i_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .phase(phase), .instr_retire(instr_retire),
   .retire_cycles(retire_cycles), .file_rd_en(file_rd_en), .file_addr(file_addr),
   .file_wr_en(file_wr_en), .wreg_wr_en(wreg_wr_en), .ptr_sel(ptr_sel),
   .stack_push(stack_push), .stack_pop(stack_pop));
